// File: rtl/efic_pkg.sv
// package of constants and types for the error-flag and interrupt command block
// assumes one 20 MHz clock and an avalon-mm slave reached by software
//
// Functional notes
// RL1: code 35 copies accumulator to global parameter
// RL2: direct mode reply status 100, value meaningless
// RL3: code 36 clears error flags chosen by type
// RL4: type 0 all, 1..5 single flags
// RL5: code 25 enables interrupt numbered by type
// RL6: number 255 sets global interrupt enable
// RL7: code 26 disables interrupt numbered by type
// RL8: number 255 clears global interrupt enable
// RL9: vector define stores label per interrupt
// RL10: label must point at handler start
// RL11: later vector define overwrites earlier one
// RL12: vector define meant for standalone programs
// RL13: vector define is code 37, label in value
// RL14: code 38 restores saved context, resumes flow
// RL15: full accumulator copied unmodified
// RL16: frame is nine bytes, value msb first
// RL17: checksum is sum of eight bytes mod 256
package efic_pkg;
	// ****************************************
	// command codes and status
	// ****************************************
	localparam logic [7:0] EFIC_OP_AGP = 8'h23; // accu_to_global_param, 35
	localparam logic [7:0] EFIC_OP_CLR = 8'h24; // error clear, 36
	localparam logic [7:0] EFIC_OP_UNMASK = 8'h19; // interrupt_unmask_cmd, 25
	localparam logic [7:0] EFIC_OP_MASKOFF = 8'h1a; // interrupt_mask_off_cmd, 26
	localparam logic [7:0] EFIC_OP_VEC = 8'h25; // handler_entry_define, 37
	localparam logic [7:0] EFIC_OP_RET = 8'h26; // handler_return, 38
	localparam logic [7:0] EFIC_ST_OK = 8'h64; // status 100
	localparam logic [7:0] EFIC_ST_BADSUM = 8'h01; // checksum fault
	localparam logic [7:0] EFIC_ST_BADOP = 8'h02; // unknown code
	localparam logic [7:0] EFIC_GLOBAL_IRQ = 8'hff; // global interrupt number
	localparam logic [7:0] EFIC_MY_ADDR = 8'h01; // default target address
	localparam logic [7:0] EFIC_HOST_ADDR = 8'h02; // reply host address
	// ****************************************
	// sizes
	// ****************************************
	localparam int EFIC_NIRQ = 16; // interrupt sources held
	localparam int EFIC_NGP = 16; // global parameter words held
	localparam int EFIC_FRAME_LEN = 9;
	localparam logic [3:0] EFIC_LAST_BYTE = 4'h8;
	// error flag bit positions
	localparam int EFIC_F_TIMEOUT = 0;
	localparam int EFIC_F_ALARM = 1;
	localparam int EFIC_F_DEV = 2;
	localparam int EFIC_F_POS = 3;
	localparam int EFIC_F_SHUT = 4;
	// ****************************************
	// avalon register byte offsets
	// ****************************************
	localparam logic [7:0] EFIC_R_RXBYTE = 8'h00; // w: frame byte in, r: accept count
	localparam logic [7:0] EFIC_R_REPLY = 8'h04; // r: status, code
	localparam logic [7:0] EFIC_R_ERRFLAG = 8'h08; // r: error flags
	localparam logic [7:0] EFIC_R_IRQEN = 8'h0c; // r: source enables, bit 31 global
	localparam logic [7:0] EFIC_R_ACCU = 8'h10; // rw: accumulator
	localparam logic [7:0] EFIC_R_XREG = 8'h14; // rw: x register
	localparam logic [7:0] EFIC_R_PC = 8'h18; // rw: program counter
	localparam logic [7:0] EFIC_R_EVSTAT = 8'h1c; // r: sticky events
	localparam logic [7:0] EFIC_R_EVCLR = 8'h20; // w: clear events
	localparam logic [7:0] EFIC_R_EVEN = 8'h24; // rw: event enables
	localparam logic [7:0] EFIC_R_GPSEL = 8'h28; // rw: global parameter index
	localparam logic [7:0] EFIC_R_GPDATA = 8'h2c; // r: selected parameter
	localparam logic [7:0] EFIC_R_VECSEL = 8'h30; // rw: vector index
	localparam logic [7:0] EFIC_R_VECDATA = 8'h34; // r: selected vector
	localparam logic [7:0] EFIC_R_SAVE = 8'h38; // w: save context snapshot
	localparam logic [31:0] EFIC_BAD_READ = 32'hdeadbeef; // unmapped read answer
	// event bits
	localparam int EFIC_EV_DONE = 0; // command executed
	localparam int EFIC_EV_FAULT = 1; // command refused
	localparam int EFIC_EV_W = 2;
	typedef struct packed {
		logic [31:0] accu;
		logic [31:0] xreg;
		logic [31:0] pc;
		logic [7:0] flags;
	} efic_ctx_t;
endpackage : efic_pkg

// File: rtl/efic_frame.sv
// nine byte command frame assembler with checksum check
// assumes bytes arrive one per i_valid pulse, in frame order
`timescale 1ns/1ns
module efic_frame
	import efic_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	output logic o_done,
	output logic o_sum_ok,
	output logic [7:0] o_addr,
	output logic [7:0] o_op,
	output logic [7:0] o_type,
	output logic [7:0] o_bank,
	output logic [31:0] o_value
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [3:0] idx; // byte position in frame
		logic [7:0] sum; // running modulo-256 sum
		logic [63:0] body; // first eight bytes
		logic done;
		logic ok;
	} efic_frm_t;
	efic_frm_t s_q, s_d;

	// byte collection; checksum compared at ninth byte
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (i_valid) begin
			if (s_q.idx == EFIC_LAST_BYTE) begin
				s_d.done = 1'b1;
				s_d.ok = (s_q.sum == i_byte); // see RL17
				s_d.idx = 4'h0;
				s_d.sum = 8'h00;
			end else begin
				s_d.body = {s_q.body[55:0], i_byte}; // see RL16
				s_d.sum = s_q.sum + i_byte; // see RL17
				s_d.idx = s_q.idx + 4'h1;
			end
		end
	end

	// one register stage for the whole state
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_done = s_q.done;
	assign o_sum_ok = s_q.ok;
	assign o_addr = s_q.body[63:56];
	assign o_op = s_q.body[55:48];
	assign o_type = s_q.body[47:40];
	assign o_bank = s_q.body[39:32];
	assign o_value = s_q.body[31:0]; // msb arrived first, see RL16

	a_frame_sum: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_valid && s_q.idx == EFIC_LAST_BYTE) |=> (o_done && o_sum_ok == ($past(s_q.sum) == $past(i_byte))))
		else $error("frame checksum verdict wrong"); // see RL17
endmodule : efic_frame

// File: rtl/efic_top.sv
// command interpreter for accumulator transfer, error clear and interrupt setup
// assumes an avalon-mm master; frames arrive as byte writes to the rx register
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module efic_top
	import efic_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic [4:0] i_flag_set, // hardware error events
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq,
	output logic o_reply_valid
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [31:0] rdata;
		logic wreq; // waitrequest, low only in the cycle the answer is given
		logic irq;
		logic rvalid;
		logic [7:0] rstat; // last reply status
		logic [7:0] rop; // last reply code
		logic [7:0] flags; // error flags
		logic gie; // global interrupt enable
		logic [EFIC_NIRQ-1:0] ien;
		logic [31:0] accu;
		logic [31:0] xreg;
		logic [31:0] pc;
		efic_ctx_t save; // context saved by a write to the save register
		logic [EFIC_NGP*32-1:0] gpar;
		logic [EFIC_NIRQ*32-1:0] vec;
		logic [3:0] gpsel;
		logic [3:0] vsel;
		logic [EFIC_EV_W-1:0] evst;
		logic [EFIC_EV_W-1:0] even;
		logic [15:0] nacc; // accepted frame count
	} efic_st_t;
	efic_st_t s_q, s_d;

	logic f_done, f_ok;
	logic [7:0] f_addr, f_op, f_type, f_bank;
	logic [31:0] f_value;
	logic bus_acc; // request taken this cycle, answered in the next
	logic rx_push;

	// apply byte enables to a 32 bit word
	function automatic logic [31:0] efic_merge(input logic [31:0] old_w,
			input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
		end
		return r;
	endfunction : efic_merge

	// type byte to error flag clear mask, unknown codes clear nothing
	function automatic logic [7:0] efic_clr_mask(input logic [7:0] t);
		logic [7:0] m;
		m = 8'h00;
		case (t)
			8'h00: m = 8'h1f; // all flags
			8'h01: m[EFIC_F_TIMEOUT] = 1'b1; // timeout_flag
			8'h02: m[EFIC_F_ALARM] = 1'b1; // external_alarm_flag
			8'h03: m[EFIC_F_DEV] = 1'b1; // deviation_flag
			8'h04: m[EFIC_F_POS] = 1'b1; // position_error_flag
			8'h05: m[EFIC_F_SHUT] = 1'b1; // shutdown_flag
			default: m = 8'h00;
		endcase
		return m;
	endfunction : efic_clr_mask

	// the answer comes one cycle after the request is seen
	assign bus_acc = (i_read || i_write) && s_q.wreq;
	assign rx_push = bus_acc && i_write && i_address == EFIC_R_RXBYTE && i_byteenable[0];

	efic_frame u_frame (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_valid(rx_push),
		.i_byte(i_writedata[7:0]),
		.o_done(f_done),
		.o_sum_ok(f_ok),
		.o_addr(f_addr),
		.o_op(f_op),
		.o_type(f_type),
		.o_bank(f_bank),
		.o_value(f_value)
	);

	// ****************************************
	// command execution and register bus
	// ****************************************
	always_comb begin
		logic [7:0] clr;
		logic [EFIC_EV_W-1:0] ev;
		logic [3:0] gidx;
		clr = 8'h00;
		ev = '0;
		gidx = 4'h0;
		s_d = s_q;
		s_d.wreq = !bus_acc;
		s_d.rvalid = 1'b0;
		// hardware error events
		s_d.flags = s_q.flags | {3'h0, i_flag_set};
		// frames for other addresses are silently dropped
		if (f_done && f_addr == EFIC_MY_ADDR) begin
			s_d.rvalid = 1'b1;
			s_d.rop = f_op;
			s_d.rstat = EFIC_ST_OK; // see RL2
			if (!f_ok) begin
				s_d.rstat = EFIC_ST_BADSUM; // see RL17
				ev[EFIC_EV_FAULT] = 1'b1;
			end else begin
				s_d.nacc = s_q.nacc + 16'h0001;
				case (f_op)
					EFIC_OP_AGP: begin
						// bank and parameter index folded into the held words
						gidx = f_type[3:0] ^ {f_bank[1:0], 2'b00};
						s_d.gpar[gidx*32 +: 32] = s_q.accu; // see RL1, see RL15
					end
					EFIC_OP_CLR: begin
						clr = efic_clr_mask(f_type); // see RL3, see RL4
					end
					EFIC_OP_UNMASK: begin
						if (f_type == EFIC_GLOBAL_IRQ) s_d.gie = 1'b1; // see RL6
						else if (f_type < 8'(EFIC_NIRQ)) s_d.ien[f_type[3:0]] = 1'b1; // see RL5
					end
					EFIC_OP_MASKOFF: begin
						if (f_type == EFIC_GLOBAL_IRQ) s_d.gie = 1'b0; // see RL8
						else if (f_type < 8'(EFIC_NIRQ)) s_d.ien[f_type[3:0]] = 1'b0; // see RL7
					end
					EFIC_OP_VEC: begin
						// newest label always wins, see RL11
						if (f_type < 8'(EFIC_NIRQ)) s_d.vec[f_type[3:0]*32 +: 32] = f_value; // see RL9, see RL13
					end
					EFIC_OP_RET: begin
						s_d.accu = s_q.save.accu; // see RL14
						s_d.xreg = s_q.save.xreg;
						s_d.pc = s_q.save.pc;
						s_d.flags = s_q.save.flags | {3'h0, i_flag_set};
					end
					default: begin
						s_d.rstat = EFIC_ST_BADOP;
						ev[EFIC_EV_FAULT] = 1'b1;
					end
				endcase
				if (s_d.rstat == EFIC_ST_OK) ev[EFIC_EV_DONE] = 1'b1;
			end
		end
		// new hardware events win over the clear
		s_d.flags = s_d.flags & ~clr | {3'h0, i_flag_set};
		// register writes
		if (bus_acc && i_write) begin
			case (i_address)
				EFIC_R_ACCU: s_d.accu = efic_merge(s_q.accu, i_writedata, i_byteenable);
				EFIC_R_XREG: s_d.xreg = efic_merge(s_q.xreg, i_writedata, i_byteenable);
				EFIC_R_PC: s_d.pc = efic_merge(s_q.pc, i_writedata, i_byteenable);
				EFIC_R_EVCLR: s_d.evst = s_q.evst & ~i_writedata[EFIC_EV_W-1:0];
				EFIC_R_EVEN: s_d.even = i_writedata[EFIC_EV_W-1:0];
				EFIC_R_GPSEL: s_d.gpsel = i_writedata[3:0];
				EFIC_R_VECSEL: s_d.vsel = i_writedata[3:0];
				EFIC_R_SAVE: s_d.save = {s_q.accu, s_q.xreg, s_q.pc, s_q.flags};
				default: s_d.save = s_d.save; // unmapped writes ignored
			endcase
		end
		// events set after the clear so they are never lost
		s_d.evst = s_d.evst | ev;
		s_d.irq = |(s_d.evst & s_d.even);
		// register reads
		s_d.rdata = 32'h0;
		if (bus_acc && i_read) begin
			case (i_address)
				EFIC_R_RXBYTE: s_d.rdata = {16'h0, s_q.nacc};
				EFIC_R_REPLY: s_d.rdata = {EFIC_HOST_ADDR, EFIC_MY_ADDR, s_q.rstat, s_q.rop};
				EFIC_R_ERRFLAG: s_d.rdata = {24'h0, s_q.flags};
				EFIC_R_IRQEN: s_d.rdata = {s_q.gie, 15'h0, s_q.ien};
				EFIC_R_ACCU: s_d.rdata = s_q.accu;
				EFIC_R_XREG: s_d.rdata = s_q.xreg;
				EFIC_R_PC: s_d.rdata = s_q.pc;
				EFIC_R_EVSTAT: s_d.rdata = {30'h0, s_q.evst};
				EFIC_R_EVEN: s_d.rdata = {30'h0, s_q.even};
				EFIC_R_GPSEL: s_d.rdata = {28'h0, s_q.gpsel};
				EFIC_R_GPDATA: s_d.rdata = s_q.gpar[s_q.gpsel*32 +: 32];
				EFIC_R_VECSEL: s_d.rdata = {28'h0, s_q.vsel};
				EFIC_R_VECDATA: s_d.rdata = s_q.vec[s_q.vsel*32 +: 32];
				default: s_d.rdata = EFIC_BAD_READ;
			endcase
		end
	end

	// single register stage
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			// waitrequest stands high through reset so no request is answered early
			s_q <= '{wreq: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_readdata = s_q.rdata;
	assign o_waitrequest = s_q.wreq;
	assign o_irq = s_q.irq;
	assign o_reply_valid = s_q.rvalid;

	// ****************************************
	// checks
	// ****************************************
	a_agp_copy: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_AGP)
		|=> s_q.gpar[$past(f_type[3:0] ^ {f_bank[1:0], 2'b00})*32 +: 32] == $past(s_q.accu))
		else $error("accumulator not copied"); // see RL1
	a_reply_ok: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_CLR)
		|=> (o_reply_valid && s_q.rstat == EFIC_ST_OK))
		else $error("reply status not ok"); // see RL2
	a_clear_all: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_CLR && f_type == 8'h00
		&& i_flag_set == 5'h0) |=> s_q.flags == 8'h00)
		else $error("clear all left flags"); // see RL3
	a_clear_one: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_CLR && f_type == 8'h03
		&& i_flag_set == 5'h0) |=> (!s_q.flags[EFIC_F_DEV] && s_q.flags[EFIC_F_TIMEOUT]
		== $past(s_q.flags[EFIC_F_TIMEOUT])))
		else $error("single clear wrong"); // see RL4
	a_unmask_one: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_UNMASK
		&& f_type < 8'(EFIC_NIRQ))
		|=> (s_q.ien[$past(f_type[3:0])] && s_q.gie == $past(s_q.gie)))
		else $error("source enable not set"); // see RL5
	a_global_on: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_UNMASK
		&& f_type == EFIC_GLOBAL_IRQ) |=> (s_q.gie && s_q.ien == $past(s_q.ien)))
		else $error("global enable not set"); // see RL6
	a_mask_one: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_MASKOFF
		&& f_type < 8'(EFIC_NIRQ))
		|=> !s_q.ien[$past(f_type[3:0])])
		else $error("source enable not cleared"); // see RL7
	a_global_off: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_MASKOFF
		&& f_type == EFIC_GLOBAL_IRQ) |=> !s_q.gie)
		else $error("global enable not cleared"); // see RL8
	a_vec_store: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_VEC
		&& f_type < 8'(EFIC_NIRQ))
		|=> s_q.vec[$past(f_type[3:0])*32 +: 32] == $past(f_value))
		else $error("vector not stored"); // see RL9
	a_ret_restore: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(f_done && f_ok && f_addr == EFIC_MY_ADDR && f_op == EFIC_OP_RET && !bus_acc)
		|=> (s_q.accu == $past(s_q.save.accu) && s_q.pc == $past(s_q.save.pc)))
		else $error("context not restored"); // see RL14
	a_bus_wait: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_read && o_waitrequest) |=> !o_waitrequest)
		else $error("answer not in one cycle");
	c_agp: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		f_done && f_ok && f_op == EFIC_OP_AGP);
	c_vec_twice: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		f_done && f_ok && f_op == EFIC_OP_VEC ##[9:200] f_done && f_ok && f_op == EFIC_OP_VEC);
	c_bad_sum: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) f_done && !f_ok);
	c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) o_irq);
endmodule : efic_top

// File: sim/efic_host_model.sv
// host side model: an avalon master that sends nine byte command frames
// assumes one clock and a slave that answers with waitrequest low
`timescale 1ns/1ns
module efic_host_model
	import efic_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_waitrequest,
	input wire logic i_reply_valid,
	output logic [7:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	output logic [3:0] o_byteenable
);
	// ****************************************
	// bus cycles
	// ****************************************
	// idle values at time zero
	initial begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h00000000;
		o_byteenable = 4'hf;
	end

	// one transfer; released lines carry the inverse so stale data never passes
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_address <= a;
		o_writedata <= d;
		o_read <= rd;
		o_write <= !rd;
		do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~d;
	endtask : xfer

	// whole frame, value most significant byte first, then the sum byte
	task automatic frame(input logic [7:0] ta, input logic [7:0] op, input logic [7:0] ty,
			input logic [7:0] bk, input logic [31:0] v, input logic bad, output logic seen);
		logic [7:0] b [9];
		logic [7:0] s;
		int k;
		b = '{ta, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		s = 8'h00;
		for (k = 0; k < 8; k++) begin
			s = s + b[k];
		end
		// a corrupt sum is only sent when the bench asks for a refusal
		b[8] = bad ? ~s : s;
		for (k = 0; k < 9; k++) begin
			xfer(1'b0, EFIC_R_RXBYTE, {24'h000000, b[k]});
		end
		seen = 1'b0;
		// the reply pulse is due two cycles after the last byte
		for (k = 0; k < 6; k++) begin
			@(posedge i_ref_clk);
			seen = seen | i_reply_valid;
		end
	endtask : frame
endmodule : efic_host_model

// File: sim/efic_tb_top.sv
// self-checking bench for the error-flag and interrupt command block
// assumes the host model drives the register bus; reads are checked by a monitor
`timescale 1ns/1ns
module efic_tb_top;
	import efic_pkg::*;
	// ****************************************
	// signals and instances
	// ****************************************
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [4:0] i_flag_set = 5'h00; // hardware error events
	logic [7:0] i_address;
	logic i_read;
	logic i_write;
	logic [31:0] i_writedata;
	logic [3:0] i_byteenable;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic o_irq;
	logic o_reply_valid;
	int fails = 0;
	int n_compared = 0;
	logic [31:0] exp_q [$]; // expected read data, oldest first
	logic [31:0] rng = 32'd63;
	logic [31:0] a;
	logic [31:0] x;
	logic [31:0] p;
	logic [31:0] v;
	logic seen;

	always #25 i_ref_clk = ~i_ref_clk;

	efic_top dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .i_flag_set(i_flag_set), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_irq(o_irq), .o_reply_valid(o_reply_valid));

	efic_host_model host (.i_ref_clk(i_ref_clk), .i_waitrequest(o_waitrequest),
		.i_reply_valid(o_reply_valid), .o_address(i_address), .o_read(i_read),
		.o_write(i_write), .o_writedata(i_writedata), .o_byteenable(i_byteenable));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		host.xfer(1'b1, ad, 32'h00000000);
	endtask : rd

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		host.xfer(1'b0, ad, d);
	endtask : wr

	// good frame to this device; motor/bank is a random don't-care, value comes from the caller
	task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val);
		logic s;
		host.frame(EFIC_MY_ADDR, op, ty, 8'(xs()), val, 1'b0, s);
		chk({31'h0, s}, 32'h00000001);
	endtask : cmd

	task automatic flags(input logic [4:0] f);
		@(posedge i_ref_clk);
		i_flag_set <= f;
		@(posedge i_ref_clk);
		i_flag_set <= 5'h00;
	endtask : flags

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// read monitor: data counts only at the edge where waitrequest is low
	always @(posedge i_ref_clk) begin
		if (i_read === 1'b1 && o_waitrequest === 1'b0) begin
			chk(o_readdata, exp_q.pop_front());
		end
	end

	// watchdog, far beyond the fewer than a thousand cycles the sequence needs
	initial begin
		#1000000;
		fails++;
		conclude();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		rd(EFIC_R_IRQEN, 32'h00000000);
		rd(EFIC_R_ERRFLAG, 32'h00000000);
		rd(8'h3c, EFIC_BAD_READ);
		// accumulator copy, index 5 ^ (1 << 2) = 1
		a = xs();
		wr(EFIC_R_ACCU, a);
		host.frame(EFIC_MY_ADDR, EFIC_OP_AGP, 8'h05, 8'h01, xs(), 1'b0, seen);
		chk({31'h0, seen}, 32'h00000001);
		wr(EFIC_R_GPSEL, 32'h00000001);
		rd(EFIC_R_GPDATA, a);
		rd(EFIC_R_REPLY, {EFIC_HOST_ADDR, EFIC_MY_ADDR, EFIC_ST_OK, EFIC_OP_AGP});
		// error clear by single flag, then a type with no flag, then all
		flags(5'h1f);
		for (int t = 1; t <= 5; t++) begin
			cmd(EFIC_OP_CLR, t[7:0], xs());
			rd(EFIC_R_ERRFLAG, {27'h0, 5'h1f << t});
		end
		flags(5'h1f);
		cmd(EFIC_OP_CLR, 8'h06, 32'h00000000);
		rd(EFIC_R_ERRFLAG, 32'h0000001f);
		cmd(EFIC_OP_CLR, 8'h00, xs());
		rd(EFIC_R_ERRFLAG, 32'h00000000);
		// source and global enables
		cmd(EFIC_OP_UNMASK, 8'h03, xs());
		cmd(EFIC_OP_UNMASK, 8'h0f, xs());
		cmd(EFIC_OP_UNMASK, EFIC_GLOBAL_IRQ, xs());
		rd(EFIC_R_IRQEN, 32'h80008008);
		cmd(EFIC_OP_MASKOFF, 8'h03, xs());
		rd(EFIC_R_IRQEN, 32'h80008000);
		cmd(EFIC_OP_MASKOFF, EFIC_GLOBAL_IRQ, xs());
		rd(EFIC_R_IRQEN, 32'h00008000);
		// vectors; labels stand for handler entry points of a stored program
		v = xs();
		cmd(EFIC_OP_VEC, 8'h02, v);
		cmd(EFIC_OP_VEC, 8'h07, v);
		x = v;
		v = xs();
		cmd(EFIC_OP_VEC, 8'h02, v);
		wr(EFIC_R_VECSEL, 32'h00000002);
		rd(EFIC_R_VECDATA, v);
		wr(EFIC_R_VECSEL, 32'h00000007);
		rd(EFIC_R_VECDATA, x);
		// context save, disturb everything, then restore
		a = xs();
		x = xs();
		p = xs();
		wr(EFIC_R_ACCU, a);
		wr(EFIC_R_XREG, x);
		wr(EFIC_R_PC, p);
		wr(EFIC_R_SAVE, 32'h00000000);
		wr(EFIC_R_ACCU, ~a);
		wr(EFIC_R_XREG, ~x);
		wr(EFIC_R_PC, ~p);
		flags(5'h04);
		cmd(EFIC_OP_RET, EFIC_GLOBAL_IRQ, 32'h00000000);
		rd(EFIC_R_ACCU, a);
		rd(EFIC_R_XREG, x);
		rd(EFIC_R_PC, p);
		rd(EFIC_R_ERRFLAG, 32'h00000000);
		// events and interrupt: only refusals enabled
		wr(EFIC_R_EVCLR, 32'h00000003);
		wr(EFIC_R_EVEN, 32'h00000002);
		cmd(EFIC_OP_CLR, 8'h00, 32'h00000000);
		repeat (2) @(posedge i_ref_clk);
		#1 chk({31'h0, o_irq}, 32'h00000000);
		host.frame(EFIC_MY_ADDR, EFIC_OP_UNMASK, EFIC_GLOBAL_IRQ, 8'h00, 0, 1'b1, seen);
		rd(EFIC_R_REPLY, {EFIC_HOST_ADDR, EFIC_MY_ADDR, EFIC_ST_BADSUM, EFIC_OP_UNMASK});
		rd(EFIC_R_IRQEN, 32'h00008000);
		rd(EFIC_R_EVSTAT, 32'h00000003);
		#1 chk({31'h0, o_irq}, 32'h00000001);
		wr(EFIC_R_EVCLR, 32'h00000002);
		repeat (2) @(posedge i_ref_clk);
		#1 chk({31'h0, o_irq}, 32'h00000000);
		rd(EFIC_R_EVSTAT, 32'h00000001);
		// a frame for another target is dropped without a reply
		host.frame(8'h05, EFIC_OP_CLR, 8'h00, 8'h00, 32'h00000000, 1'b0, seen);
		chk({31'h0, seen}, 32'h00000000);
		// an unknown code still gets a reply, with the refusal status
		cmd(8'h7f, 8'h00, xs());
		rd(EFIC_R_REPLY, {EFIC_HOST_ADDR, EFIC_MY_ADDR, EFIC_ST_BADOP, 8'h7f});
		// nineteen good frames reached this target; bad sum and foreign ones do not count
		rd(EFIC_R_RXBYTE, 32'h00000013);
		repeat (2) @(posedge i_ref_clk);
		conclude();
	end
endmodule : efic_tb_top
